// >>> verilog/acs_sequencer.sv
// Calibrate and convert sequencer of a delta-sigma measurement converter.
//
// Operation
// - After reset, hold everything in power-on reset for about ten milliseconds.
// - Then spend 1800 master clock cycles waking up.
// - Commands seen at power-on or during wake-up are held until wake-up ends.
// - With nothing pending at wake-up end, enter standby.
// - Trim and sample requests both high start calibration; immediately from standby.
// - Calibration does an offset step then a gain step, giving zero and slope.
// - Calibration lasts 3246 master cycles; coefficients are kept for later conversions.
// - Both ranges use the same factors; signed range adds 8000h.
// - At calibration end, sample request low goes to standby, high converts.
// - Sample request re-raised with trim high restarts calibration.
// - Sample request re-raised with trim low is ignored during calibration.
// - The range select input is ignored during calibration.
// - Sample request held high converts continuously, 1622 master cycles each.
// - Internal half-rate clock delays a standby start by up to two cycles.
// - A standby start converts for 1624 master cycles, then ready falls.
// - A sample request rise with trim low during conversion restarts the conversion; with trim high it calibrates.
// - Trim pulse with sample held high calibrates, then ready marks first result; here a trim pulse alone is ignored while converting.
// - The filter settles in one conversion, so the first result is valid.
// - Unipolar results are straight binary, signed range results offset binary.
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
module acs_sequencer
#(
   parameter int unsigned POR_CYCLES = `ACS_POR_CYC
)
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // Converter pins
   input  wire logic                   master_clock_in,
   input  wire logic                   trim_request,
   input  wire logic                   sample_request,
   input  wire logic                   signed_range_select,
   output logic                        result_ready_n,
   // Front end and serial port side
   input  wire logic [15:0]            modulator_word,
   output logic                        cal_offset_active,
   output logic                        cal_gain_active,
   output logic                        convert_active,
   output logic      [15:0]            result_word,
   output logic                        result_bipolar,
   // AXI4-Lite register bus
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [`ACS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   output logic      [1:0]             s_axi_bresp,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire logic [`ACS_ADDR_W-1:0] s_axi_araddr,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output logic      [31:0]            s_axi_rdata,
   output logic      [1:0]             s_axi_rresp
);
   import acs_pkg::*;

   // ************************************************************************
   // Result scaling
   // ************************************************************************
   // Gain is unsigned with 8000h as unity. The signed range reuses the unipolar
   // slope below its zero point, so no second calibration is needed.
   function automatic logic [15:0] acs_scale
   (
      input logic [15:0] raw,
      input logic [15:0] zero,
      input logic [15:0] gain,
      input logic        bipolar
   );
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      logic signed [18:0] val;
      begin
         diff = $signed({1'b0, raw}) - $signed({1'b0, zero});
         prod = diff * $signed({1'b0, gain});
         val  = 19'(prod >>> `ACS_GAIN_SHIFT);
         if (bipolar)
            val = val + `ACS_BP_OFFSET;
         if (val < 19'sh00000)
            acs_scale = 16'h0000;
         else if (val > `ACS_RESULT_MAX)
            acs_scale = 16'hffff;
         else
            acs_scale = val[15:0];
      end
   endfunction : acs_scale

   // ************************************************************************
   // Pins and registers
   // ************************************************************************
   logic [`ACS_PINS-1:0]   pin_q;
   logic [`ACS_CTRL_W-1:0] ctrl;
   logic [31:0]            status_word;
   logic                   trim;
   logic                   sample;
   logic                   bipolar;
   logic                   mclk_en;
   logic                   half_en;
   logic                   sample_rise;
   logic                   both_high;
   logic [11:0]            sample_request_len;
   acs_seq_t               r;
   acs_seq_t               next_r;

   acs_pin_sync u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_raw ({signed_range_select, sample_request, trim_request, master_clock_in}),
      .pin_q   (pin_q)
   );

   acs_axil_regs u_regs
   (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .awvalid     (s_axi_awvalid),
      .awready     (s_axi_awready),
      .awaddr      (s_axi_awaddr),
      .wvalid      (s_axi_wvalid),
      .wready      (s_axi_wready),
      .wdata       (s_axi_wdata),
      .wstrb       (s_axi_wstrb),
      .bvalid      (s_axi_bvalid),
      .bready      (s_axi_bready),
      .bresp       (s_axi_bresp),
      .arvalid     (s_axi_arvalid),
      .arready     (s_axi_arready),
      .araddr      (s_axi_araddr),
      .rvalid      (s_axi_rvalid),
      .rready      (s_axi_rready),
      .rdata       (s_axi_rdata),
      .rresp       (s_axi_rresp),
      .ctrl        (ctrl),
      .status_word (status_word),
      .result_word ({16'h0000, r.result}),
      .coef_word   ({r.gain, r.zero})
   );

   // Software may take over the three command inputs for bring-up.
   assign trim    = ctrl[`ACS_CTRL_SRC] ? ctrl[`ACS_CTRL_SW_TRIM]   : pin_q[`ACS_PIN_TRIM];
   assign sample  = ctrl[`ACS_CTRL_SRC] ? ctrl[`ACS_CTRL_SW_SAMPLE] : pin_q[`ACS_PIN_SAMPLE];
   assign bipolar = ctrl[`ACS_CTRL_SRC] ? ctrl[`ACS_CTRL_SW_RANGE]  : pin_q[`ACS_PIN_RANGE];

   assign mclk_en     = pin_q[`ACS_PIN_MCLK] && !r.mclk_prev;
   assign half_en     = mclk_en && r.half_phase;
   assign sample_rise = sample && !r.sample_prev;
   assign both_high   = trim && sample;
   assign sample_request_len    = r.stby_start ? `ACS_SAMPLE_REQUEST_STBY_CYC : `ACS_SAMPLE_REQUEST_CYC;

   assign status_word = {21'h000000, r.result_bp, r.ready_n, r.cal_done, 1'b0, r.state};

   // ************************************************************************
   // Sequencer
   // ************************************************************************
   always_comb
   begin
      next_r             = r;
      next_r.mclk_prev   = pin_q[`ACS_PIN_MCLK];
      next_r.sample_prev = sample;
      if (mclk_en)
         next_r.half_phase = !r.half_phase;
      unique case (r.state)
         st_por:
         begin
            next_r.pend_cal  = r.pend_cal || both_high;
            next_r.pend_sample_request = r.pend_sample_request || sample;
            next_r.por_cnt   = r.por_cnt + 21'd1;
            if (r.por_cnt == 21'(POR_CYCLES - 1))
            begin
               next_r.state = st_wake;
               next_r.cnt   = 12'd0;
            end
         end

         st_wake:
         begin
            next_r.pend_cal  = r.pend_cal || both_high;
            next_r.pend_sample_request = r.pend_sample_request || sample;
            if (mclk_en)
            begin
               next_r.cnt = r.cnt + 12'd1;
               if (r.cnt == `ACS_WAKE_CYC - 12'd1)
               begin
                  next_r.cnt       = 12'd0;
                  next_r.pend_cal  = 1'b0;
                  next_r.pend_sample_request = 1'b0;
                  if (r.pend_cal || both_high)
                     next_r.state = st_cal_ofs;
                  else if (r.pend_sample_request || sample)
                     next_r.state = st_align;
                  else
                     next_r.state = st_standby;
               end
            end
         end

         st_standby:
         begin
            next_r.cnt = 12'd0;
            if (both_high)
               next_r.state = st_cal_ofs;
            else if (sample)
               next_r.state = st_align;
         end

         st_cal_ofs:
         begin
            // The range select input plays no part here.
            if (sample_rise && trim)
               next_r.cnt = 12'd0;
            else if (mclk_en)
            begin
               next_r.cnt = r.cnt + 12'd1;
               if (r.cnt == `ACS_CAL_OFS_CYC - 12'd1)
               begin
                  next_r.zero  = modulator_word;
                  next_r.cnt   = 12'd0;
                  next_r.state = st_cal_gain;
               end
            end
         end

         st_cal_gain:
         begin
            if (sample_rise && trim)
            begin
               next_r.cnt   = 12'd0;
               next_r.state = st_cal_ofs;
            end
            else if (mclk_en)
            begin
               next_r.cnt = r.cnt + 12'd1;
               if (r.cnt == `ACS_CAL_GAIN_CYC - 12'd1)
               begin
                  next_r.gain     = modulator_word;
                  next_r.cal_done = 1'b1;
                  next_r.cnt      = 12'd0;
                  if (sample)
                  begin
                     next_r.stby_start = 1'b0;
                     next_r.state      = st_convert;
                  end
                  else
                     next_r.state = st_standby;
               end
            end
         end

         st_align:
         begin
            // Starting on the half-rate phase costs up to two master cycles.
            if (half_en)
            begin
               next_r.cnt        = 12'd0;
               next_r.stby_start = 1'b1;
               next_r.state      = st_convert;
            end
         end

         st_convert:
         begin
            // Both requests high means calibrate, which outranks a restart.
            if (sample_rise && trim)
            begin
               next_r.cnt   = 12'd0;
               next_r.state = st_cal_ofs;
            end
            else if (sample_rise)
            begin
               next_r.cnt        = 12'd0;
               next_r.stby_start = 1'b0;
               next_r.ready_n    = 1'b1;
            end
            else if (mclk_en)
            begin
               next_r.cnt = r.cnt + 12'd1;
               if (r.cnt == 12'd0)
                  next_r.ready_n = 1'b1;
               if (r.cnt == sample_request_len - 12'd1)
               begin
                  // Range select is read here, not latched at the start.
                  next_r.result     = acs_scale(modulator_word, r.zero, r.gain, bipolar);
                  next_r.result_bp  = bipolar;
                  next_r.ready_n    = 1'b0;
                  next_r.cnt        = 12'd0;
                  next_r.stby_start = 1'b0;
                  if (!sample)
                     next_r.state = st_standby;
               end
            end
         end

         default:
         begin
            next_r.state = st_standby;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r         <= '0;
         r.state   <= st_por;
         // Unity gain until the first calibration ends; no offset until its offset step ends.
         r.gain    <= `ACS_GAIN_RST;
         r.zero    <= `ACS_ZERO_RST;
         r.ready_n <= 1'b1;
      end
      else
         r <= next_r;
   end

   // ************************************************************************
   // Outputs
   // ************************************************************************
   assign result_ready_n    = r.ready_n;
   assign result_word       = r.result;
   assign result_bipolar    = r.result_bp;
   assign cal_offset_active = r.state == st_cal_ofs;
   assign cal_gain_active   = r.state == st_cal_gain;
   assign convert_active    = r.state == st_convert;

endmodule : acs_sequencer
`default_nettype wire

// >>> verilog/acs_cfg.svh
// Constants of the converter control sequencer: counts, offsets, fields and reset values.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ****************************************************************************
// Timing
// ****************************************************************************
`define ACS_CLK_KHZ        125000
`define ACS_POR_MS         10
`define ACS_POR_CYC        (`ACS_POR_MS * `ACS_CLK_KHZ)
`define ACS_WAKE_CYC       12'd1800
`define ACS_CAL_CYC        12'd3246
`define ACS_CAL_OFS_CYC    (`ACS_CAL_CYC / 12'd2)
`define ACS_CAL_GAIN_CYC   (`ACS_CAL_CYC - `ACS_CAL_OFS_CYC)
`define ACS_SAMPLE_REQUEST_CYC       12'd1622
`define ACS_SAMPLE_REQUEST_STBY_CYC  12'd1624

// ****************************************************************************
// Result arithmetic
// ****************************************************************************
`define ACS_BP_OFFSET      19'sh08000
`define ACS_RESULT_MAX     19'sh0ffff
`define ACS_GAIN_SHIFT     15
`define ACS_GAIN_RST       16'h8000
`define ACS_ZERO_RST       16'h0000

// ****************************************************************************
// Pin vector positions
// ****************************************************************************
`define ACS_PINS           4
`define ACS_PIN_MCLK       0
`define ACS_PIN_TRIM       1
`define ACS_PIN_SAMPLE     2
`define ACS_PIN_RANGE      3

// ****************************************************************************
// Register map
// ****************************************************************************
`define ACS_ADDR_W         8
`define ACS_REG_CTRL       8'h00
`define ACS_REG_STATUS     8'h04
`define ACS_REG_RESULT     8'h08
`define ACS_REG_COEF       8'h0c
`define ACS_CTRL_W         4
`define ACS_CTRL_RST       4'h0
`define ACS_CTRL_SRC       0
`define ACS_CTRL_SW_TRIM   1
`define ACS_CTRL_SW_SAMPLE 2
`define ACS_CTRL_SW_RANGE  3
`define ACS_RESP_OKAY      2'b00
`define ACS_RESP_SLVERR    2'b10

`endif

// >>> verilog/acs_pkg.sv
// Types shared by the converter control sequencer modules.
`include "acs_cfg.svh"
package acs_pkg;

   typedef enum logic [6:0]
   {
      st_por      = 7'h01,
      st_wake     = 7'h02,
      st_standby  = 7'h04,
      st_cal_ofs  = 7'h08,
      st_cal_gain = 7'h10,
      st_align    = 7'h20,
      st_convert  = 7'h40
   } acs_state_t;

   typedef struct packed
   {
      logic [`ACS_PINS-1:0] s1;
      logic [`ACS_PINS-1:0] s2;
      logic [`ACS_PINS-1:0] s3;
      logic [`ACS_PINS-1:0] q;
   } acs_sync_t;

   typedef struct packed
   {
      logic                   aw_got;
      logic                   w_got;
      logic [`ACS_ADDR_W-1:0] waddr;
      logic [31:0]            wdata;
      logic [3:0]             wstrb;
      logic                   bvalid;
      logic [1:0]             bresp;
      logic                   rvalid;
      logic [31:0]            rdata;
      logic [1:0]             rresp;
      logic [`ACS_CTRL_W-1:0] ctrl;
   } acs_axil_t;

   typedef struct packed
   {
      acs_state_t  state;
      logic [20:0] por_cnt;
      logic [11:0] cnt;
      logic        mclk_prev;
      logic        half_phase;
      logic        sample_prev;
      logic        pend_cal;
      logic        pend_sample_request;
      logic        stby_start;
      logic [15:0] zero;
      logic [15:0] gain;
      logic [15:0] result;
      logic        result_bp;
      logic        ready_n;
      logic        cal_done;
   } acs_seq_t;

endpackage : acs_pkg

// >>> verilog/acs_pin_sync.sv
// Three-stage synchroniser for the asynchronous control pins and master clock.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
module acs_pin_sync
(
   // Clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // Pins
   input  wire logic [`ACS_PINS-1:0] pin_raw,
   output logic      [`ACS_PINS-1:0] pin_q
);
   import acs_pkg::*;

   acs_sync_t r;
   acs_sync_t next_r;

   // A bit changes only once the second and third stages agree.
   always_comb
   begin
      next_r    = r;
      next_r.s1 = pin_raw;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      next_r.q  = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         r <= '0;
      else
         r <= next_r;
   end

   assign pin_q = r.q;

endmodule : acs_pin_sync
`default_nettype wire

// >>> verilog/acs_axil_regs.sv
// AXI4-Lite slave holding the control register and reading back sequencer state.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
module acs_axil_regs
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // Write address and data
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [`ACS_ADDR_W-1:0] awaddr,
   input  wire logic                   wvalid,
   output logic                        wready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   // Write response
   output logic                        bvalid,
   input  wire logic                   bready,
   output logic      [1:0]             bresp,
   // Read
   input  wire logic                   arvalid,
   output logic                        arready,
   input  wire logic [`ACS_ADDR_W-1:0] araddr,
   output logic                        rvalid,
   input  wire logic                   rready,
   output logic      [31:0]            rdata,
   output logic      [1:0]             rresp,
   // Register contents
   output logic      [`ACS_CTRL_W-1:0] ctrl,
   input  wire logic [31:0]            status_word,
   input  wire logic [31:0]            result_word,
   input  wire logic [31:0]            coef_word
);
   import acs_pkg::*;

   acs_axil_t r;
   acs_axil_t next_r;

   assign awready = !r.aw_got && !r.bvalid;
   assign wready  = !r.w_got && !r.bvalid;
   assign arready = !r.rvalid;

   always_comb
   begin
      next_r = r;
      if (awvalid && awready)
      begin
         next_r.aw_got = 1'b1;
         next_r.waddr  = awaddr;
      end
      if (wvalid && wready)
      begin
         next_r.w_got = 1'b1;
         next_r.wdata = wdata;
         next_r.wstrb = wstrb;
      end
      // Address and data may arrive in either order; the response waits for both.
      if (r.aw_got && r.w_got)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp  = `ACS_RESP_OKAY;
         unique case (r.waddr)
            `ACS_REG_CTRL:
            begin
               if (r.wstrb[0])
                  next_r.ctrl = r.wdata[`ACS_CTRL_W-1:0];
            end
            `ACS_REG_STATUS, `ACS_REG_RESULT, `ACS_REG_COEF:
            begin
               next_r.bresp = `ACS_RESP_OKAY;
            end
            default:
            begin
               next_r.bresp = `ACS_RESP_SLVERR;
            end
         endcase
      end
      if (r.bvalid && bready)
         next_r.bvalid = 1'b0;
      if (arvalid && arready)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = `ACS_RESP_OKAY;
         unique case (araddr)
            `ACS_REG_CTRL:   next_r.rdata = {28'h0000000, r.ctrl};
            `ACS_REG_STATUS: next_r.rdata = status_word;
            `ACS_REG_RESULT: next_r.rdata = result_word;
            `ACS_REG_COEF:   next_r.rdata = coef_word;
            default:
            begin
               next_r.rdata = 32'h00000000;
               next_r.rresp = `ACS_RESP_SLVERR;
            end
         endcase
      end
      else if (r.rvalid && rready)
         next_r.rvalid = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r      <= '0;
         r.ctrl <= `ACS_CTRL_RST;
      end
      else
         r <= next_r;
   end

   assign bvalid = r.bvalid;
   assign bresp  = r.bresp;
   assign rvalid = r.rvalid;
   assign rdata  = r.rdata;
   assign rresp  = r.rresp;
   assign ctrl   = r.ctrl;

endmodule : acs_axil_regs
`default_nettype wire

// >>> tb/acs_host_model.sv
// Host side model: free running master clock at one eighth of aclk.
`timescale 1ns/100ps
`default_nettype none
module acs_host_model
(
   // Clock
   input  wire logic aclk,
   output logic      mclk
);
   logic [2:0] div = 3'h0;
   // A crystal never stops, so the clock runs between frames too.
   always_ff @(posedge aclk)
   begin
      div <= div + 3'h1;
   end
   assign mclk = div[2];
endmodule : acs_host_model
`default_nettype wire

// >>> tb/acs_sequencer_asserts.sv
// Port-level checks of the converter control sequencer.
`timescale 1ns/100ps
`default_nettype none
module acs_sequencer_asserts
#(
   parameter int unsigned POR_CYCLES = 20
)
(
   // Watched ports
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        result_ready_n,
   input wire logic        cal_offset_active,
   input wire logic        cal_gain_active,
   input wire logic        convert_active,
   input wire logic [15:0] result_word
);
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_idle: assert property
      ($rose(aresetn) |-> result_ready_n && !result_word) else $error("not idle");
   a_one_state: assert property
      ($onehot0({cal_offset_active, cal_gain_active, convert_active})) else $error("states");
   a_gain_order: assert property
      ($rose(cal_gain_active) |-> $past(cal_offset_active)) else $error("gain first");
   a_ofs_holds: assert property
      ($rose(cal_offset_active) |=> cal_offset_active [*8]) else $error("short offset");
   a_gain_holds: assert property
      ($rose(cal_gain_active) |=> cal_gain_active [*8]) else $error("short gain");
   a_ready_cause: assert property
      ($fell(result_ready_n) |-> $past(convert_active)) else $error("ready no sample_request");
   a_result_ready: assert property
      ($changed(result_word) |-> !result_ready_n) else $error("result no ready");
   a_ready_holds: assert property
      ($fell(result_ready_n) |=> !result_ready_n [*3]) else $error("ready glitch");
   c_cal: cover property ($rose(cal_offset_active));
   c_sample_request: cover property ($rose(convert_active));
   c_ready: cover property ($fell(result_ready_n));
endmodule : acs_sequencer_asserts
bind acs_sequencer acs_sequencer_asserts #(.POR_CYCLES(POR_CYCLES)) acs_sequencer_asserts_inst
(
   .aclk, .aresetn, .result_ready_n, .cal_offset_active, .cal_gain_active,
   .convert_active, .result_word
);
`default_nettype wire

// >>> tb/tb_adc_calibrate_convert_sequencer.sv
// Self-checking bench of the converter control sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "acs_cfg.svh"
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_adc_calibrate_convert_sequencer;
   logic aclk = 1'b0, aresetn = 1'b0, trim_request = 1'b0, sample_request = 1'b0;
   logic signed_range_select = 1'b0, master_clock_in, result_ready_n, cal_offset_active;
   logic cal_gain_active, convert_active, result_bipolar;
   logic [15:0] result_word, modulator_word = 16'h1234;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int num_errors = 0, n_tests = 0, cyc = 0, c;
   acs_sequencer #(.POR_CYCLES(20)) acs_sequencer_inst
   (
      .aclk, .aresetn, .master_clock_in, .trim_request, .sample_request,
      .signed_range_select, .result_ready_n, .modulator_word, .cal_offset_active,
      .cal_gain_active, .convert_active, .result_word, .result_bipolar,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp
   );
   acs_host_model acs_host_model_inst (.aclk, .mclk(master_clock_in));
   initial forever #4 aclk = ~aclk;
   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         num_errors++;
         finish_test;
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   // A result may still be flagged from before, so wait for it to clear first.
   task automatic wait_rdy;
      while (result_ready_n === 1'b0)
      begin
         @(posedge aclk);
         c++;
      end
      do
      begin
         @(posedge aclk);
         c++;
      end
      while (result_ready_n !== 1'b0);
   endtask : wait_rdy
   task automatic t_wake;
      repeat (2000) @(posedge aclk);
      sample_request <= 1'b1;
      signed_range_select <= 1'b1;
      repeat (1000) @(posedge aclk);
      `CHK("sample_request_wake", 1'b0, convert_active)
      sample_request <= 1'b0;
      repeat (12000) @(posedge aclk);
      sample_request <= 1'b1;
      repeat (100) @(posedge aclk);
      sample_request <= 1'b0;
      wait_rdy;
      `CHK("late", 1'b1, cyc > 27300)
      `CHK("restart", 1'b1, cyc > 27900 && cyc < 28100)
      `CHK("res_bp", 16'h9234, result_word)
      `CHK("bp", 1'b1, result_bipolar)
   endtask : t_wake
   task automatic t_regs;
      repeat (100) @(posedge aclk);
      rd(`ACS_REG_STATUS);
      `CHK("state", 7'h04, d[6:0])
      rd(`ACS_REG_COEF);
      `CHK("coef", 32'h80000000, d)
      rd(8'h10);
      `CHK("rresp", `ACS_RESP_SLVERR, r)
      wr(8'h10, 32'h0);
      `CHK("bresp_bad", `ACS_RESP_SLVERR, r)
      wr(`ACS_REG_CTRL, 32'h0);
      `CHK("bresp", `ACS_RESP_OKAY, r)
   endtask : t_regs
   task automatic t_stby;
      c = 0;
      sample_request <= 1'b1;
      signed_range_select <= 1'b0;
      repeat (100) @(posedge aclk);
      sample_request <= 1'b0;
      c = 100;
      wait_rdy;
      `CHK("t_stby", 1'b1, c >= 12984 && c <= 13024)
      `CHK("res_up", 16'h1234, result_word)
   endtask : t_stby
   task automatic t_cal;
      c = 0;
      trim_request <= 1'b1;
      sample_request <= 1'b1;
      signed_range_select <= 1'b1;
      repeat (40) @(posedge aclk);
      `CHK("ofs", 1'b1, cal_offset_active)
      trim_request <= 1'b0;
      signed_range_select <= 1'b0;
      repeat (100) @(posedge aclk);
      signed_range_select <= 1'b1;
      c = 140;
      wait_rdy;
      `CHK("t_cal", 1'b1, c >= 38936 && c <= 38976)
      `CHK("res_cal", 16'h8000, result_word)
      signed_range_select <= 1'b0;
      c = 0;
      wait_rdy;
      `CHK("t_cont", 1'b1, c >= 12975 && c <= 12977)
      `CHK("res_cal_up", 16'h0000, result_word)
      sample_request <= 1'b0;
   endtask : t_cal
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_wake;
      t_regs;
      t_stby;
      t_cal;
      finish_test;
   end
endmodule : tb_adc_calibrate_convert_sequencer
`default_nettype wire
